// file: dmb_pkg.sv
// Package with register map, field positions and types for the basic DMA channel.
package dmb_pkg;
    localparam logic [7:0] OFF_CON = 8'h00;
    localparam logic [7:0] OFF_ECON = 8'h04;
    localparam logic [7:0] OFF_INT = 8'h08;
    localparam logic [7:0] OFF_SSA = 8'h0c;
    localparam logic [7:0] OFF_DSA = 8'h10;
    localparam logic [7:0] OFF_SSIZ = 8'h14;
    localparam logic [7:0] OFF_DSIZ = 8'h18;
    localparam logic [7:0] OFF_SPTR = 8'h1c;
    localparam logic [7:0] OFF_DPTR = 8'h20;
    localparam logic [7:0] OFF_CSIZ = 8'h24;
    localparam logic [7:0] OFF_CPTR = 8'h28;
    localparam logic [7:0] OFF_IPC = 8'h2c;
    localparam int CON_EN = 7;
    localparam int CON_AUTO = 4;
    localparam int ECON_FORCE = 7;
    localparam int ECON_ABORT = 6;
    localparam int ECON_START_REQUEST_ENABLE = 4;
    localparam int ECON_ABORT_REQUEST_ENABLE = 3;
    localparam int ECON_SNUM_LO = 8;
    localparam int ECON_ANUM_LO = 16;
    localparam int INT_ERR = 0;
    localparam int INT_ABORT = 1;
    localparam int INT_BLOCK = 3;
    localparam int INT_DHALF = 4;
    localparam int INT_DDONE = 5;
    localparam int INT_SHALF = 6;
    localparam int INT_SDONE = 7;
    localparam logic [31:0] IPC_MASK = 32'h1f1f1f1f;
    localparam logic [31:0] INT_MASK = 32'h000000fb;
    localparam logic [8:0] FULL_SIZE = 9'h100;
    typedef struct packed {
        logic [2:0] prio;
        logic [1:0] sub;
    } dmb_prio_s;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } dmb_mreq_s;
endpackage

// file: dmb_channel.sv
// Basic transfer mode DMA channel with Wishbone slave registers and Wishbone master port.
// Overview of operation
// RULE_01: Priority 000 disables, 001 to 111 levels.
// RULE_02: Subpriority 00 to 11 maps levels zero-three.
// RULE_03: Priority word packs four channel fields.
// RULE_04: Software writes zero to reserved priority bits.
// RULE_05: Transfer modes may be active together.
// RULE_06: Transaction reads source then writes destination.
// RULE_07: Each start event moves one cell.
// RULE_08: Block length is larger of both sizes.
// RULE_09: Start addresses are physical, sizes independent.
// RULE_10: Force bit starts a cell transfer.
// RULE_11: Matching start interrupt starts a cell.
// RULE_12: Channel stays enabled until block is moved.
// RULE_13: Disabled channel ignores starts until re-enabled.
// RULE_14: Half flags set at half the size.
// RULE_15: Done flags set when counters reach end.
// RULE_16: Abort bit or abort interrupt cancels request.
// RULE_17: Error, cell end or block end cancel request; block end cancels only with auto enable off.
// RULE_18: Any abort sets the transfer abort flag.
// RULE_19: Transaction in progress finishes before stopping.
// RULE_20: Start writes and abort reset read-only pointers.
// RULE_21: Address error and block completion flags reported.
// RULE_22: Cell size zero means 256 bytes.
// RULE_23: Pattern match acts like block completion; the code has no pattern match.
// RULE_24: Pointers and flags update after each transaction.
//
// Register access over Wishbone and the register addresses were left to the implementer.
module dmb_channel
    import dmb_pkg::*;
#(
    parameter int IRQ_W = 8
)
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [7:0] wbs_adr_in,
    input wire logic [31:0] wbs_dat_in,
    input wire logic [3:0] wbs_sel_in,
    input wire logic wbs_we_in,
    input wire logic wbs_cyc_in,
    input wire logic wbs_stb_in,
    output logic [31:0] wbs_dat_out,
    output logic wbs_ack_out,
    input wire logic [IRQ_W-1:0] irq_num_in,
    input wire logic irq_valid_in,
    output logic wbm_cyc_out,
    output logic wbm_stb_out,
    output logic wbm_we_out,
    output logic [31:0] wbm_adr_out,
    output logic [31:0] wbm_dat_out,
    output logic [3:0] wbm_sel_out,
    input wire logic [31:0] wbm_dat_in,
    input wire logic wbm_ack_in,
    input wire logic wbm_err_in,
    output logic [3:0][2:0] irq_priority_out,
    output logic [3:0][1:0] irq_subpriority_out,
    output logic [3:0] irq_enabled_out
);

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dmb_state_e;

    dmb_state_e state;
    logic [31:0] irq_prio_reg;
    logic channel_enable_bit;
    logic auto_enable_bit;
    logic [7:0] start_request_number;
    logic [7:0] abort_request_number;
    logic start_request_enable;
    logic abort_request_enable;
    logic [7:0] int_flags;
    logic [31:0] source_start_address;
    logic [31:0] destination_start_address;
    logic [7:0] source_size;
    logic [7:0] destination_size;
    logic [7:0] cell_size;
    logic [8:0] source_pointer;
    logic [8:0] destination_pointer;
    logic [8:0] cell_pointer;
    logic pending;
    logic abort_req;
    logic [7:0] irq_num_s1;
    logic [7:0] irq_num_s2;
    logic irq_valid_s1;
    logic irq_valid_s2;
    dmb_mreq_s mreq;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_mux;
    logic [31:0] wmask;
    logic [31:0] wvalue;
    logic [8:0] ssz;
    logic [8:0] dsz;
    logic [8:0] blk_len;
    logic [8:0] csz;
    logic [8:0] nsp;
    logic [8:0] ndp;
    logic [8:0] ncp;
    logic blk_done;
    logic cell_done;
    logic start_evt;
    logic abort_evt;
    logic sw_abort;
    logic force_wr;
    logic ssa_wr;
    logic dsa_wr;
    logic txn_end;
    logic bus_err;

    assign wr_hit = wbs_cyc_in && wbs_stb_in && wbs_we_in && !wbs_ack_out;
    assign rd_hit = wbs_cyc_in && wbs_stb_in && !wbs_we_in && !wbs_ack_out;
    assign wmask = {{8{wbs_sel_in[3]}}, {8{wbs_sel_in[2]}}, {8{wbs_sel_in[1]}},
                    {8{wbs_sel_in[0]}}};
    assign wvalue = wbs_dat_in & wmask;
    assign force_wr = wr_hit && wbs_adr_in == OFF_ECON && wvalue[ECON_FORCE];
    assign sw_abort = wr_hit && wbs_adr_in == OFF_ECON && wvalue[ECON_ABORT];
    assign ssa_wr = wr_hit && wbs_adr_in == OFF_SSA;
    assign dsa_wr = wr_hit && wbs_adr_in == OFF_DSA;

    // A size of zero stands for a full 256-byte region.
    assign ssz = (source_size == 8'h00) ? FULL_SIZE : {1'b0, source_size};
    assign dsz = (destination_size == 8'h00) ? FULL_SIZE : {1'b0, destination_size};
    assign csz = (cell_size == 8'h00) ? FULL_SIZE : {1'b0, cell_size}; // [RULE_22]
    assign blk_len = (ssz > dsz) ? ssz : dsz; // [RULE_08]

    // One byte per transaction keeps both pointers aligned for any pair of sizes.
    assign nsp = (source_pointer + 9'h001 >= ssz) ? 9'h000 : source_pointer + 9'h001;
    assign ndp = (destination_pointer + 9'h001 >= dsz) ? 9'h000
                 : destination_pointer + 9'h001;
    assign ncp = cell_pointer + 9'h001;
    assign txn_end = (state == ST_WRITE) && (wbm_ack_in || wbm_err_in);
    assign bus_err = (state != ST_IDLE) && wbm_err_in;
    // The larger side never wraps inside a block, so its pointer counts the whole block.
    assign blk_done = txn_end && !wbm_err_in
        && ((ssz >= dsz) ? source_pointer : destination_pointer) + 9'h001 == blk_len; // [RULE_12]
    assign cell_done = txn_end && !wbm_err_in && (ncp >= csz); // [RULE_07]

    assign start_evt = channel_enable_bit && (force_wr // [RULE_10]
        || (irq_valid_s2 && start_request_enable
            && irq_num_s2 == start_request_number)); // [RULE_11] [RULE_13]
    assign abort_evt = sw_abort || (irq_valid_s2 && abort_request_enable
        && irq_num_s2 == abort_request_number); // [RULE_16]

    always_ff @(posedge core_clk_in)
    begin
        irq_num_s1 <= 8'(irq_num_in);
        irq_num_s2 <= irq_num_s1;
        irq_valid_s1 <= irq_valid_in;
        irq_valid_s2 <= irq_valid_s1;
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (wbs_adr_in)
            OFF_CON: rd_mux = {24'h000000, channel_enable_bit, 2'b00, auto_enable_bit, 4'h0};
            OFF_ECON: rd_mux = {8'h00, abort_request_number, start_request_number,
                                3'b000, start_request_enable, abort_request_enable, 3'b000};
            OFF_INT: rd_mux = {24'h000000, int_flags};
            OFF_SSA: rd_mux = source_start_address;
            OFF_DSA: rd_mux = destination_start_address;
            OFF_SSIZ: rd_mux = {24'h000000, source_size};
            OFF_DSIZ: rd_mux = {24'h000000, destination_size};
            OFF_SPTR: rd_mux = {24'h000000, source_pointer[7:0]};
            OFF_DPTR: rd_mux = {24'h000000, destination_pointer[7:0]};
            OFF_CSIZ: rd_mux = {24'h000000, cell_size};
            OFF_CPTR: rd_mux = {24'h000000, cell_pointer[7:0]};
            OFF_IPC: rd_mux = irq_prio_reg & IPC_MASK; // [RULE_04]
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            wbs_ack_out <= 1'b0;
            wbs_dat_out <= 32'h0000_0000;
        end
        else
        begin
            wbs_ack_out <= wbs_cyc_in && wbs_stb_in && !wbs_ack_out;
            if (rd_hit)
                wbs_dat_out <= rd_mux;
        end
    end

    // Each channel's priority and subpriority fields share one word.
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            irq_prio_reg <= 32'h0000_0000;
        else if (wr_hit && wbs_adr_in == OFF_IPC)
            irq_prio_reg <= ((irq_prio_reg & ~wmask) | wvalue) & IPC_MASK; // [RULE_03]
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            irq_priority_out <= '0;
            irq_subpriority_out <= '0;
            irq_enabled_out <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                irq_priority_out[i] <= irq_prio_reg[8*i+2 +: 3]; // [RULE_01]
                irq_subpriority_out[i] <= irq_prio_reg[8*i +: 2]; // [RULE_02]
                irq_enabled_out[i] <= irq_prio_reg[8*i+2 +: 3] != 3'b000; // [RULE_01]
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            start_request_number <= 8'h00;
            abort_request_number <= 8'h00;
            start_request_enable <= 1'b0;
            abort_request_enable <= 1'b0;
            auto_enable_bit <= 1'b0;
            source_start_address <= 32'h0000_0000;
            destination_start_address <= 32'h0000_0000;
            source_size <= 8'h00;
            destination_size <= 8'h00;
            cell_size <= 8'h00;
        end
        else if (wr_hit)
        begin
            unique case (wbs_adr_in)
                OFF_CON: auto_enable_bit <= wbs_sel_in[0] ? wbs_dat_in[CON_AUTO] : auto_enable_bit;
                OFF_ECON:
                begin
                    if (wbs_sel_in[0])
                    begin
                        start_request_enable <= wbs_dat_in[ECON_START_REQUEST_ENABLE];
                        abort_request_enable <= wbs_dat_in[ECON_ABORT_REQUEST_ENABLE];
                    end
                    if (wbs_sel_in[1])
                        start_request_number <= wbs_dat_in[ECON_SNUM_LO +: 8];
                    if (wbs_sel_in[2])
                        abort_request_number <= wbs_dat_in[ECON_ANUM_LO +: 8];
                end
                OFF_SSA: source_start_address <= (source_start_address & ~wmask) | wvalue; // [RULE_09]
                OFF_DSA: destination_start_address <= (destination_start_address & ~wmask) | wvalue;
                OFF_SSIZ: source_size <= wbs_sel_in[0] ? wbs_dat_in[7:0] : source_size;
                OFF_DSIZ: destination_size <= wbs_sel_in[0] ? wbs_dat_in[7:0] : destination_size;
                OFF_CSIZ: cell_size <= wbs_sel_in[0] ? wbs_dat_in[7:0] : cell_size;
                default: ;
            endcase
        end
    end

    // Channel enable: set by software, cleared by block end when auto enable is off, or by address error.
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            channel_enable_bit <= 1'b0;
        else if (blk_done && !auto_enable_bit)
            channel_enable_bit <= 1'b0; // [RULE_12]
        else if (bus_err)
            channel_enable_bit <= 1'b0;
        else if (wr_hit && wbs_adr_in == OFF_CON && wbs_sel_in[0])
            channel_enable_bit <= wbs_dat_in[CON_EN]; // [RULE_13]
    end

    // Pending request; cancel sources are checked ahead of a new start.
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            pending <= 1'b0;
            abort_req <= 1'b0;
        end
        else
        begin
            if (abort_evt || bus_err || cell_done || (blk_done && !auto_enable_bit))
                pending <= 1'b0; // [RULE_16] [RULE_17]
            else if (start_evt)
                pending <= 1'b1;
            // A transaction already on the bus runs to its end before the stop.
            if (abort_evt && state != ST_IDLE)
                abort_req <= 1'b1; // [RULE_19]
            else if (state == ST_IDLE || txn_end)
                abort_req <= 1'b0;
        end
    end

    // Pointer moves after each transaction; flags set at the same edge, set wins.
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            source_pointer <= 9'h000;
            destination_pointer <= 9'h000;
            cell_pointer <= 9'h000;
            int_flags <= 8'h00;
        end
        else
        begin
            if (wr_hit && wbs_adr_in == OFF_INT)
                int_flags <= int_flags & ~(wvalue[7:0] & INT_MASK[7:0]);
            if (txn_end && !wbm_err_in)
            begin
                source_pointer <= nsp; // [RULE_24]
                destination_pointer <= ndp; // [RULE_24]
                cell_pointer <= cell_done ? 9'h000 : ncp;
                if (source_pointer + 9'h001 == (ssz >> 1))
                    int_flags[INT_SHALF] <= 1'b1; // [RULE_14]
                if (destination_pointer + 9'h001 == (dsz >> 1))
                    int_flags[INT_DHALF] <= 1'b1; // [RULE_14]
                if (source_pointer + 9'h001 == ssz)
                    int_flags[INT_SDONE] <= 1'b1; // [RULE_15]
                if (destination_pointer + 9'h001 == dsz)
                    int_flags[INT_DDONE] <= 1'b1; // [RULE_15]
                if (blk_done)
                    int_flags[INT_BLOCK] <= 1'b1; // [RULE_21]
            end
            if (bus_err)
                int_flags[INT_ERR] <= 1'b1; // [RULE_21]
            if (abort_evt)
                int_flags[INT_ABORT] <= 1'b1; // [RULE_18]
            if (blk_done || (abort_evt && state == ST_IDLE) || (txn_end && abort_req)
                || ssa_wr || dsa_wr)
            begin
                cell_pointer <= 9'h000;
            end
            if (blk_done || (abort_evt && state == ST_IDLE) || (txn_end && abort_req) || ssa_wr)
                source_pointer <= 9'h000; // [RULE_20]
            if (blk_done || (abort_evt && state == ST_IDLE) || (txn_end && abort_req) || dsa_wr)
                destination_pointer <= 9'h000; // [RULE_20]
        end
    end

    // Bus master: read the source byte then write it to the destination.
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            state <= ST_IDLE;
            mreq <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (pending && channel_enable_bit && !abort_evt)
                    begin
                        state <= ST_READ; // [RULE_06]
                        mreq <= '{cyc: 1'b1, stb: 1'b1, we: 1'b0,
                                  adr: source_start_address + 32'(source_pointer),
                                  dat: 32'h0, sel: 4'h1};
                    end
                ST_READ:
                    if (wbm_err_in)
                    begin
                        state <= ST_IDLE;
                        mreq <= '0;
                    end
                    else if (wbm_ack_in)
                    begin
                        state <= ST_WRITE;
                        mreq <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1,
                                  adr: destination_start_address + 32'(destination_pointer),
                                  dat: {24'h0, wbm_dat_in[7:0]}, sel: 4'h1};
                    end
                ST_WRITE:
                    if (wbm_ack_in || wbm_err_in)
                    begin
                        state <= ST_IDLE;
                        mreq <= '0;
                    end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Modes are independent enables on the same datapath, never exclusive.
    assign wbm_cyc_out = mreq.cyc; // [RULE_05]
    assign wbm_stb_out = mreq.stb;
    assign wbm_we_out = mreq.we;
    assign wbm_adr_out = mreq.adr;
    assign wbm_dat_out = mreq.dat;
    assign wbm_sel_out = mreq.sel;

endmodule

// file: dmb_channel_assertions.sv
// Concurrent checks on the ports of the basic DMA channel.
module dmb_channel_assertions
    import dmb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [7:0] wbs_adr_in,
    input wire logic [31:0] wbs_dat_in,
    input wire logic [3:0] wbs_sel_in,
    input wire logic wbs_we_in,
    input wire logic wbs_cyc_in,
    input wire logic wbs_stb_in,
    input wire logic wbs_ack_out,
    input wire logic wbm_cyc_out,
    input wire logic wbm_stb_out,
    input wire logic wbm_we_out,
    input wire logic [31:0] wbm_adr_out,
    input wire logic [31:0] wbm_dat_out,
    input wire logic [3:0] wbm_sel_out,
    input wire logic [31:0] wbm_dat_in,
    input wire logic wbm_ack_in,
    input wire logic wbm_err_in,
    input wire logic [3:0][2:0] irq_priority_out,
    input wire logic [3:0][1:0] irq_subpriority_out,
    input wire logic [3:0] irq_enabled_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    sequence s_rd_ok;
        wbm_stb_out && !wbm_we_out && wbm_ack_in && !wbm_err_in;
    endsequence
    sequence s_ipc_wr;
        wbs_cyc_in && wbs_stb_in && wbs_we_in && wbs_ack_out
            && wbs_adr_in == OFF_IPC && wbs_sel_in == 4'hf;
    endsequence
    property p_rd_then_wr;
        s_rd_ok |=> wbm_stb_out && wbm_we_out;
    endproperty
    a_rd_then_wr: assert property (p_rd_then_wr) else $error("no write after read");
    property p_wr_data;
        s_rd_ok |=> wbm_dat_out[7:0] == $past(wbm_dat_in[7:0]);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data differs");
    property p_sel;
        wbm_stb_out |-> wbm_sel_out == 4'h1;
    endproperty
    a_sel: assert property (p_sel) else $error("wrong byte lanes");
    property p_hold;
        wbm_stb_out && !wbm_ack_in && !wbm_err_in
            |=> wbm_stb_out && $stable(wbm_adr_out) && $stable(wbm_we_out);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
    // A failed access disables the channel, so the bus must stay quiet for the next eight cycles.
    property p_err_stop;
        wbm_stb_out && wbm_err_in |=> !wbm_cyc_out [*8];
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("bus used after error");
    property p_prio3;
        s_ipc_wr |-> ##2 irq_priority_out[3] == $past(wbs_dat_in[28:26], 2);
    endproperty
    a_prio3: assert property (p_prio3) else $error("ch3 priority wrong");
    property p_sub0;
        s_ipc_wr |-> ##2 irq_subpriority_out[0] == $past(wbs_dat_in[1:0], 2);
    endproperty
    a_sub0: assert property (p_sub0) else $error("ch0 subpriority wrong");
    property p_en;
        irq_enabled_out == {irq_priority_out[3] != 3'h0, irq_priority_out[2] != 3'h0,
            irq_priority_out[1] != 3'h0, irq_priority_out[0] != 3'h0};
    endproperty
    a_en: assert property (p_en) else $error("enable decode wrong");
endmodule

bind dmb_channel dmb_channel_assertions u_chk (.*);

// file: dmb_mem_model.sv
// Byte memory on the channel's bus master port; addresses with top byte ee answer with err.
module dmb_mem_model
(
    input wire logic core_clk_in,
    input wire logic cyc_in,
    input wire logic stb_in,
    input wire logic we_in,
    input wire logic [31:0] adr_in,
    input wire logic [31:0] dat_in,
    input wire logic [3:0] lat_in,
    output logic [31:0] dat_out = 32'h0,
    output logic ack_out = 1'b0,
    output logic err_out = 1'b0,
    output int n_wr_out = 0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [256];
    int wait_cnt = 0;
    // Read data is garbage outside an answer, so a late sample shows up.
    always_ff @(posedge core_clk_in)
    begin
        ack_out <= 1'b0;
        err_out <= 1'b0;
        dat_out <= ~dat_out;
        if (cyc_in && stb_in && !ack_out && !err_out)
        begin
            wait_cnt <= (wait_cnt < lat_in) ? wait_cnt + 1 : 0;
            if (wait_cnt >= lat_in && adr_in[31:24] == 8'hee)
                err_out <= 1'b1;
            else if (wait_cnt >= lat_in)
            begin
                ack_out <= 1'b1;
                dat_out <= {24'h0, adr_in[7:0] ^ 8'ha5};
                if (we_in)
                begin
                    mem[adr_in[7:0]] <= dat_in[7:0];
                    n_wr_out <= n_wr_out + 1;
                end
            end
        end
    end
endmodule

// file: dmb_channel_tb.sv
// Self-checking testbench for the basic DMA channel.
module dmb_channel_tb
    import dmb_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [7:0] c, s, d;
        logic [15:0] n;
        logic [7:0] fl, sp, db;
    } dmb_row_s;
    logic clk = 1'b0, srst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, irq_v = 1'b0;
    logic ack, m_cyc, m_stb, m_we, m_ack, m_err;
    logic [7:0] adr = 8'h0, irq_num = 8'h0;
    logic [31:0] wdat = 32'h0, rdat, m_adr, m_wdat, m_rdat, rd;
    logic [3:0] lat = 4'h0, m_sel, en;
    logic [3:0][2:0] prio;
    logic [3:0][1:0] sub;
    int n_mismatch = 0, num_checks = 0, base = 0, n_wr;
    dmb_row_s rows [3] = '{'{8'h02, 8'h04, 8'h04, 16'd2, 8'h50, 8'h02, 8'ha5},
        '{8'h08, 8'h04, 8'h02, 16'd4, 8'hf8, 8'h00, 8'ha7},
        '{8'h00, 8'h03, 8'h00, 16'd256, 8'hf8, 8'h00, 8'ha5}};
    dmb_channel uut (.core_clk_in(clk), .srst_in(srst), .wbs_adr_in(adr), .wbs_dat_in(wdat),
        .wbs_sel_in(4'hf), .wbs_we_in(we), .wbs_cyc_in(cyc), .wbs_stb_in(stb),
        .wbs_dat_out(rdat), .wbs_ack_out(ack), .irq_num_in(irq_num), .irq_valid_in(irq_v),
        .wbm_cyc_out(m_cyc), .wbm_stb_out(m_stb), .wbm_we_out(m_we), .wbm_adr_out(m_adr),
        .wbm_dat_out(m_wdat), .wbm_sel_out(m_sel), .wbm_dat_in(m_rdat), .wbm_ack_in(m_ack),
        .wbm_err_in(m_err), .irq_priority_out(prio), .irq_subpriority_out(sub),
        .irq_enabled_out(en));
    dmb_mem_model u_mem (.core_clk_in(clk), .cyc_in(m_cyc), .stb_in(m_stb), .we_in(m_we),
        .adr_in(m_adr), .dat_in(m_wdat), .lat_in(lat), .dat_out(m_rdat), .ack_out(m_ack),
        .err_out(m_err), .n_wr_out(n_wr));
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        we <= w;
        adr <= a;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic settle();
        int q;
        q = 0;
        while (q < 16)
        begin
            @(posedge clk);
            q = m_cyc ? 0 : q + 1;
        end
    endtask
    task automatic go(input logic [7:0] c, input logic [7:0] s, input logic [7:0] d);
        bus(1'b1, OFF_CON, 32'h0);
        bus(1'b1, OFF_SSA, 32'h100);
        bus(1'b1, OFF_DSA, 32'h200);
        bus(1'b1, OFF_SSIZ, {24'h0, s});
        bus(1'b1, OFF_DSIZ, {24'h0, d});
        bus(1'b1, OFF_CSIZ, {24'h0, c});
        bus(1'b1, OFF_INT, 32'hff);
        bus(1'b1, OFF_CON, 32'h80);
        base = n_wr;
    endtask
    // Force a cell; start number 2a and abort number 33 stay armed.
    task automatic kick();
        bus(1'b1, OFF_ECON, 32'h00332a98);
        settle();
    endtask
    task automatic pulse(input logic [7:0] n);
        irq_num <= n;
        irq_v <= 1'b1;
        @(posedge clk);
        irq_v <= 1'b0;
        settle();
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rdc(OFF_IPC, 32'h0);
        rdc(OFF_SPTR, 32'h0);
        rdc(8'h3c, 32'h0);
        bus(1'b1, OFF_IPC, IPC_MASK);
        rdc(OFF_IPC, IPC_MASK);
        chk({8'h00, prio, sub, en}, 32'h00ffffff);
        for (int p = 0; p < 8; p++)
        begin
            bus(1'b1, OFF_IPC, {4{3'h0, p[2:0], p[1:0]}});
            @(posedge clk);
            chk({8'h00, prio, sub, en},
                {8'h00, {4{p[2:0]}}, {4{p[1:0]}}, {4{p != 0}}});
        end
        foreach (rows[i])
        begin
            go(rows[i].c, rows[i].s, rows[i].d);
            kick();
            chk(n_wr - base, rows[i].n);
            rdc(OFF_INT, rows[i].fl);
            rdc(OFF_SPTR, rows[i].sp);
            chk(u_mem.mem[0], rows[i].db);
        end
        base = n_wr;
        kick();
        chk(n_wr - base, 0);
        // Two cells make one block; the channel must turn itself off after the second.
        go(8'h02, 8'h04, 8'h04);
        kick();
        kick();
        chk(n_wr - base, 4);
        rdc(OFF_CON, 32'h0);
        go(8'h02, 8'h02, 8'h02);
        bus(1'b1, OFF_CON, 32'h90);
        kick();
        rdc(OFF_CON, 32'h90);
        kick();
        chk(n_wr - base, 4);
        go(8'h01, 8'h08, 8'h08);
        pulse(8'h29);
        chk(n_wr - base, 0);
        pulse(8'h2a);
        chk(n_wr - base, 1);
        rdc(OFF_SPTR, 32'h1);
        bus(1'b1, OFF_SSA, 32'h100);
        rdc(OFF_SPTR, 32'h0);
        lat <= 4'h3;
        for (int k = 0; k < 2; k++)
        begin
            go(8'h00, 8'h00, 8'h00);
            bus(1'b1, OFF_ECON, 32'h00332a98);
            repeat (40) @(posedge clk);
            if (k == 0)
                pulse(8'h33);
            else
                bus(1'b1, OFF_ECON, 32'h00332a58);
            settle();
            rdc(OFF_INT, 32'h2);
            rdc(OFF_DPTR, 32'h0);
            chk(n_wr > base && n_wr - base < 16, 1);
        end
        lat <= 4'h0;
        go(8'h04, 8'h08, 8'h08);
        bus(1'b1, OFF_SSA, 32'hee000000);
        kick();
        bus(1'b0, OFF_INT, 32'h0);
        chk(rd & 32'h1, 32'h1);
        kick();
        chk(n_wr - base, 0);
        summarize();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
endmodule
